//--- hw/lpmc_pkg.sv
// package: modes, states, wake sources and timing constants of the low power mode controller
package lpmc_pkg;

   localparam int CLK_HZ            = 50_000_000;
   localparam int IRC_HZ            = 12_000_000;
   // resume delays after deep-sleep, counted in cycles of the previous source
   localparam int IRC_RESUME_CYC    = 4;
   localparam int XTAL_RESUME_CYC   = 4096;
   // irc start-up and flash start-up times, in nanoseconds
   localparam int IRC_START_NS      = 60_000;
   localparam int FLASH_START_NS    = 100_000;
   localparam int IRC_START_CYC     = (IRC_START_NS / 1000) * (CLK_HZ / 1_000_000);
   localparam int FLASH_START_IRC   = (FLASH_START_NS / 1000) * (IRC_HZ / 1_000_000);
   // irc cycle emulated as a divider of the system clock, rounded up
   localparam int IRC_DIV           = (CLK_HZ + IRC_HZ - 1) / IRC_HZ;
   localparam int NUM_WAKE          = 13;
   localparam int CNT_W             = 16;

   // wake source bit positions
   localparam int WK_NMI  = 0;
   localparam int WK_EXT0 = 1;
   localparam int WK_EXT3 = 4;
   localparam int WK_GPIO = 5;
   localparam int WK_WOL  = 6;
   localparam int WK_BOD  = 7;
   localparam int WK_RTC  = 8;
   localparam int WK_USB  = 9;
   localparam int WK_CAN  = 10;
   localparam int WK_WDT  = 11;
   localparam int WK_OTHER = 12;

   typedef enum logic [1:0] {
      LPMC_REQ_SLEEP = 2'h0,
      LPMC_REQ_DEEP  = 2'h1,
      LPMC_REQ_PDOWN = 2'h2,
      LPMC_REQ_NONE  = 2'h3
   } lpmc_mode_t;

   typedef enum logic [5:0] {
      LPMC_RUN    = 6'h01,
      LPMC_SLEEP  = 6'h02,
      LPMC_DEEP   = 6'h04,
      LPMC_PDOWN  = 6'h08,
      LPMC_OSC_UP = 6'h10,
      LPMC_RESUME = 6'h20
   } lpmc_state_t;

   typedef struct packed {
      logic cpu_clk_en;
      logic flash_pwr_en;
      logic sram_en;
      logic dma_clk_en;
      logic irc_out_en;
      logic irc_pwr_en;
      logic main_osc_en;
      logic rtc_osc_en;
      logic pll_en;
      logic pll_connect;
      logic clkdiv_clear;
      logic clksel_reset;
      logic pin_hold;
      logic wdt_osc_en;
      logic flash_access_en;
   } lpmc_ctrl_t;

endpackage : lpmc_pkg

//--- hw/lpmc_wake_qual.sv
// wake source qualifier: masks raw interrupt levels per mode
module lpmc_wake_qual
   import lpmc_pkg::*;
#(
   parameter int N = NUM_WAKE
) (
   input  wire logic [N-1:0] irq_i,
   input  wire logic [N-1:0] enable_i,
   input  wire logic         clockless_i,
   output wire logic         wake_o
);
   // sources able to operate with clocks stopped
   localparam logic [N-1:0] CLOCKLESS_MASK = N'({1'b0, {(N-1){1'b1}}});

   wire logic [N-1:0] active_any       = irq_i & enable_i;
   wire logic [N-1:0] active_clockless = active_any & CLOCKLESS_MASK;

   assign wake_o = clockless_i ? (|active_clockless) : (|active_any);

endmodule : lpmc_wake_qual

//--- hw/lpmc_timer.sv
// down counter with a tick enable, expires once per nonzero load
module lpmc_timer
   import lpmc_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] value_i,
   input  wire logic         tick_i,
   output wire logic         busy_o,
   output wire logic         done_o
);
   logic [W-1:0] count;
   logic         run;

   wire logic last = run && tick_i && (count == W'(1));

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count <= '0;
         run   <= 1'b0;
      end else if (load_i) begin
         count <= value_i;
         run   <= (value_i != '0);
      end else if (run && tick_i) begin
         count <= count - W'(1);
         run   <= !last;
      end
   end

   assign busy_o = run;
   assign done_o = last;

endmodule : lpmc_timer

//--- hw/lpmc_top.sv
// low power mode controller: sleep, deep-sleep and power-down entry, wake and resume timing
// Operation
// - sleep keeps dma and peripheral access, disables flash and main sram.
// - any enabled active interrupt ends sleep.
// - deep-sleep stops oscillator and clocks, keeps state, holds pins static.
// - deep-sleep gates irc output but keeps irc powered.
// - deep-sleep keeps the rtc oscillator running.
// - deep-sleep turns off and disconnects pll, clears clock dividers.
// - deep-sleep keeps flash powered.
// - deep-sleep ends on reset or an enabled clockless interrupt.
// - listed wake sources wake deep-sleep when enabled.
// - resume after 4 cycles from irc, 4096 cycles from main oscillator.
// - power-down does deep-sleep actions plus removes irc and flash power.
// - power-down stops irc, main oscillator, clocks; rtc only if enabled.
// - power-down forces flash into power-down.
// - power-down turns off plls, resets clock muxes and dividers.
// - a running watchdog keeps running through power-down.
// - flash wake timer counts 100 us of irc cycles, blocks flash access.
module lpmc_top
   import lpmc_pkg::*;
#(
   parameter int XTAL_CYC   = XTAL_RESUME_CYC,
   parameter int IRC_UP_CYC = IRC_START_CYC
) (
   input  wire logic                CLK_I,
   input  wire logic                RESET_I,
   input  wire logic                REQ_VALID_I,
   input  wire lpmc_mode_t          REQ_MODE_I,
   input  wire logic                PREV_SRC_IRC_I,
   input  wire logic                RTC_ENABLED_I,
   input  wire logic                WDT_RUNNING_I,
   input  wire logic [NUM_WAKE-1:0] WAKE_IRQ_I,
   input  wire logic [NUM_WAKE-1:0] WAKE_EN_I,
   output wire logic                REQ_READY_O,
   output lpmc_ctrl_t               CTRL_O,
   output wire logic                RESUMED_O,
   output wire lpmc_state_t         STATE_O
);
   // wake lines come from pins and other domains
   logic [NUM_WAKE-1:0] irq_meta;
   logic [NUM_WAKE-1:0] irq_sync;
   always_ff @(posedge CLK_I) begin
      irq_meta <= WAKE_IRQ_I;
      irq_sync <= irq_meta;
   end

   lpmc_state_t state;
   lpmc_state_t next_state;
   logic        prev_irc;
   logic        pd_mode;
   logic [7:0]  div_cnt;
   lpmc_ctrl_t  next_ctrl;
   lpmc_ctrl_t  ctrl;

   wire logic wake;
   wire logic clockless = (state == LPMC_DEEP) || (state == LPMC_PDOWN);
   lpmc_wake_qual #(.N(NUM_WAKE)) u_qual (
      .irq_i       (irq_sync),
      .enable_i    (WAKE_EN_I),
      .clockless_i (clockless),
      .wake_o      (wake)
   );

   // irc tick: one pulse per emulated irc cycle
   wire logic irc_tick = (div_cnt == 8'(IRC_DIV - 1));
   always_ff @(posedge CLK_I) begin
      if (RESET_I || irc_tick) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   wire logic accept = (state == LPMC_RUN) && REQ_VALID_I && (REQ_MODE_I != LPMC_REQ_NONE);
   assign REQ_READY_O = (state == LPMC_RUN);

   // oscillator start-up phase used only by power-down wake from irc
   wire logic up_busy;
   wire logic up_done;
   wire logic up_load = (state == LPMC_PDOWN) && wake && prev_irc;
   lpmc_timer #(.W(CNT_W)) u_osc_up (
      .clk_i   (CLK_I),
      .reset_i (RESET_I),
      .load_i  (up_load),
      .value_i (CNT_W'(IRC_UP_CYC)),
      .tick_i  (1'b1),
      .busy_o  (up_busy),
      .done_o  (up_done)
   );

   // resume counter: four irc cycles or xtal cycles
   wire logic res_busy;
   wire logic res_done;
   wire logic deep_wake = (state == LPMC_DEEP) && wake;
   wire logic pd_xtal   = (state == LPMC_PDOWN) && wake && !prev_irc;
   wire logic res_load  = deep_wake || pd_xtal || up_done;
   wire logic [CNT_W-1:0] res_val = prev_irc ? CNT_W'(IRC_RESUME_CYC)
                                             : CNT_W'(XTAL_CYC);
   logic res_tick_irc;
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         res_tick_irc <= 1'b0;
      end else if (res_load) begin
         res_tick_irc <= prev_irc;
      end
   end
   lpmc_timer #(.W(CNT_W)) u_resume (
      .clk_i   (CLK_I),
      .reset_i (RESET_I),
      .load_i  (res_load),
      .value_i (res_val),
      .tick_i  (res_tick_irc ? irc_tick : 1'b1),
      .busy_o  (res_busy),
      .done_o  (res_done)
   );

   // flash wake timer runs on irc cycles from power-down wake
   wire logic fl_busy;
   wire logic fl_load = (state == LPMC_PDOWN) && wake;
   lpmc_timer #(.W(CNT_W)) u_flash (
      .clk_i   (CLK_I),
      .reset_i (RESET_I),
      .load_i  (fl_load),
      .value_i (CNT_W'(FLASH_START_IRC)),
      .tick_i  (irc_tick),
      .busy_o  (fl_busy),
      .done_o  ()
   );

   // flash is blocked from the wake edge on, before the timer shows busy
   wire logic fl_block = fl_busy || fl_load;
   // the entry edge acts on the requested mode, never on a stale power-down flag
   wire logic pd_now   = accept ? (REQ_MODE_I == LPMC_REQ_PDOWN) : pd_mode;

   always_comb begin
      next_state = state;
      unique case (state)
         LPMC_RUN: begin
            if (accept) begin
               unique case (REQ_MODE_I)
                  LPMC_REQ_SLEEP: next_state = LPMC_SLEEP;
                  LPMC_REQ_DEEP:  next_state = LPMC_DEEP;
                  default:        next_state = LPMC_PDOWN;
               endcase
            end
         end
         LPMC_SLEEP:  if (wake) next_state = LPMC_RUN;
         LPMC_DEEP:   if (wake) next_state = LPMC_RESUME;
         LPMC_PDOWN:  if (wake) next_state = prev_irc ? LPMC_OSC_UP : LPMC_RESUME;
         LPMC_OSC_UP: if (up_done) next_state = LPMC_RESUME;
         LPMC_RESUME: if (res_done) next_state = LPMC_RUN;
         default:     next_state = LPMC_RUN;
      endcase
   end

   // output controls per state; clocks stay stopped until resume completes
   always_comb begin
      next_ctrl = '{cpu_clk_en: 1'b1, flash_pwr_en: 1'b1, sram_en: 1'b1, dma_clk_en: 1'b1,
                    irc_out_en: 1'b1, irc_pwr_en: 1'b1, main_osc_en: 1'b1, rtc_osc_en: 1'b1,
                    pll_en: 1'b1, pll_connect: 1'b1, clkdiv_clear: 1'b0, clksel_reset: 1'b0,
                    pin_hold: 1'b0, wdt_osc_en: 1'b1, flash_access_en: !fl_block};
      unique case (next_state)
         LPMC_SLEEP: begin
            next_ctrl.cpu_clk_en   = 1'b0;
            next_ctrl.flash_pwr_en = 1'b0;
            next_ctrl.sram_en      = 1'b0;
            next_ctrl.flash_access_en = 1'b0;
         end
         LPMC_DEEP, LPMC_PDOWN, LPMC_OSC_UP, LPMC_RESUME: begin
            next_ctrl.cpu_clk_en   = 1'b0;
            next_ctrl.dma_clk_en   = 1'b0;
            next_ctrl.main_osc_en  = 1'b0;
            next_ctrl.irc_out_en   = 1'b0;
            next_ctrl.pin_hold     = 1'b1;
            next_ctrl.pll_en       = 1'b0;
            next_ctrl.pll_connect  = 1'b0;
            next_ctrl.clkdiv_clear = 1'b1;
            next_ctrl.rtc_osc_en   = 1'b1;
            next_ctrl.wdt_osc_en   = WDT_RUNNING_I;
            next_ctrl.flash_pwr_en = 1'b1;
            if (pd_now) begin
               next_ctrl.irc_pwr_en   = 1'b0;
               next_ctrl.flash_pwr_en = 1'b0;
               next_ctrl.flash_access_en = 1'b0;
               next_ctrl.clksel_reset = 1'b1;
               next_ctrl.rtc_osc_en   = RTC_ENABLED_I;
               next_ctrl.wdt_osc_en   = WDT_RUNNING_I;
            end
            if (next_state == LPMC_OSC_UP || next_state == LPMC_RESUME) begin
               next_ctrl.irc_pwr_en   = 1'b1;
               next_ctrl.main_osc_en  = !prev_irc;
               next_ctrl.flash_pwr_en = 1'b1;
               next_ctrl.flash_access_en = !fl_block;
            end
         end
         default: begin
            next_ctrl.flash_access_en = !fl_block;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         state    <= LPMC_RUN;
         prev_irc <= 1'b1;
         pd_mode  <= 1'b0;
         ctrl     <= '{default: 1'b1, clkdiv_clear: 1'b0, clksel_reset: 1'b0, pin_hold: 1'b0};
      end else begin
         state <= next_state;
         ctrl  <= next_ctrl;
         if (accept) begin
            prev_irc <= PREV_SRC_IRC_I;
            pd_mode  <= (REQ_MODE_I == LPMC_REQ_PDOWN);
         end else if (state == LPMC_RUN && !fl_busy) begin
            pd_mode  <= 1'b0;
         end
      end
   end

   assign CTRL_O    = ctrl;
   assign STATE_O   = state;
   assign RESUMED_O = (state == LPMC_RESUME) && res_done;

   // cycles already spent in the current state; delay ranges cannot span the xtal wait
   logic [CNT_W-1:0] state_age;
   always_ff @(posedge CLK_I) begin
      if (RESET_I || next_state != state) begin
         state_age <= '0;
      end else begin
         state_age <= state_age + CNT_W'(1);
      end
   end

   // checks
   a_sleep_no_mem: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_SLEEP |-> !ctrl.sram_en && !ctrl.flash_pwr_en && ctrl.dma_clk_en)
      else $error("sleep memory gating wrong");
   a_sleep_wake: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_SLEEP && wake |=> state == LPMC_RUN)
      else $error("sleep did not end on wake");
   a_deep_gates: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_DEEP |-> !ctrl.pll_en && ctrl.clkdiv_clear && ctrl.irc_pwr_en
                            && !ctrl.irc_out_en && ctrl.flash_pwr_en && ctrl.rtc_osc_en)
      else $error("deep-sleep gating wrong");
   a_irc_resume: assert property (@(posedge CLK_I) disable iff (RESET_I)
      $rose(state == LPMC_RESUME) && res_tick_irc |-> ##[1:40] state == LPMC_RUN)
      else $error("irc resume too slow");
   a_pd_gates: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_PDOWN |-> !ctrl.irc_pwr_en && !ctrl.flash_pwr_en && ctrl.clksel_reset
                             && ctrl.wdt_osc_en == $past(WDT_RUNNING_I))
      else $error("power-down gating wrong");
   a_flash_block: assert property (@(posedge CLK_I) disable iff (RESET_I)
      pd_mode && fl_busy && state == LPMC_RUN |=> !ctrl.flash_access_en)
      else $error("flash accessed during start-up");
   a_no_req_entry: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_RUN && !accept |=> state == LPMC_RUN)
      else $error("mode entered without request");
   a_deep_clockless: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_DEEP && !wake |=> state == LPMC_DEEP)
      else $error("deep-sleep left without wake");
   a_deep_wake: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_DEEP && wake |=> state == LPMC_RESUME)
      else $error("deep-sleep ignored a wake source");
   a_deep_clocks: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_DEEP |-> !ctrl.cpu_clk_en && !ctrl.dma_clk_en && !ctrl.main_osc_en && ctrl.pin_hold)
      else $error("deep-sleep clocks or pins wrong");
   a_deep_wdt: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_DEEP |-> ctrl.wdt_osc_en == $past(WDT_RUNNING_I))
      else $error("deep-sleep watchdog clock wrong");

   a_pd_clocks: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_PDOWN |-> !ctrl.main_osc_en && !ctrl.cpu_clk_en && !ctrl.irc_out_en
                             && ctrl.rtc_osc_en == $past(RTC_ENABLED_I))
      else $error("power-down clocks wrong");
   a_pd_plls: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_PDOWN |-> !ctrl.pll_en && !ctrl.pll_connect && ctrl.clkdiv_clear
                             && ctrl.clksel_reset)
      else $error("power-down pll or mux reset wrong");
   a_flash_held: assert property (@(posedge CLK_I) disable iff (RESET_I)
      fl_busy |-> !ctrl.flash_access_en)
      else $error("flash open before start-up ended");
   a_osc_stay: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_OSC_UP && !up_done |=> state == LPMC_OSC_UP)
      else $error("oscillator start-up cut short");
   a_osc_up_len: assert property (@(posedge CLK_I) disable iff (RESET_I)
      state == LPMC_OSC_UP && up_done |-> state_age == CNT_W'(IRC_UP_CYC - 1))
      else $error("oscillator start-up length wrong");

   a_xtal_len: assert property (@(posedge CLK_I) disable iff (RESET_I)
      RESUMED_O && !res_tick_irc |-> state_age == CNT_W'(XTAL_CYC - 1))
      else $error("xtal resume length wrong");
   a_irc_len: assert property (@(posedge CLK_I) disable iff (RESET_I)
      RESUMED_O && res_tick_irc |-> state_age < CNT_W'(IRC_RESUME_CYC * IRC_DIV)
                                   && state_age >= CNT_W'((IRC_RESUME_CYC - 1) * IRC_DIV))
      else $error("irc resume length wrong");
   a_resume_pulse: assert property (@(posedge CLK_I) disable iff (RESET_I)
      RESUMED_O |=> state == LPMC_RUN && ctrl.cpu_clk_en)
      else $error("core not restarted after resume");
   a_accept_enter: assert property (@(posedge CLK_I) disable iff (RESET_I)
      accept |=> state != LPMC_RUN)
      else $error("accepted request not entered");

   c_sleep: cover property (@(posedge CLK_I) state == LPMC_SLEEP ##[1:20] state == LPMC_RUN);
   c_deep: cover property (@(posedge CLK_I) state == LPMC_DEEP ##1 state == LPMC_RESUME);
   c_pd_irc: cover property (@(posedge CLK_I) state == LPMC_OSC_UP ##1 state == LPMC_RESUME);
   c_pd_xtal: cover property (@(posedge CLK_I) state == LPMC_PDOWN ##1 state == LPMC_RESUME);
   c_flash_ready: cover property (@(posedge CLK_I) $fell(fl_busy));

endmodule : lpmc_top

//--- verif/lpmc_core_model.sv
// partner model: core mode request and wake interrupt sources
module lpmc_core_model
   import lpmc_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                reset_i,
   input  wire logic                go_i,
   input  wire lpmc_mode_t          mode_i,
   input  wire logic [NUM_WAKE-1:0] fire_i,
   input  wire logic                ready_i,
   input  wire lpmc_state_t         state_i,
   input  wire logic                resumed_i,
   output logic                     req_valid_o,
   output lpmc_mode_t               req_mode_o,
   output logic [NUM_WAKE-1:0]      irq_o,
   output logic                     reconfig_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk_i) begin
      if (reset_i) begin
         req_valid_o <= 1'b0;
         req_mode_o  <= LPMC_REQ_NONE;
         irq_o       <= '0;
         reconfig_o  <= 1'b0;
      end else begin
         if (go_i) begin
            req_valid_o <= 1'b1;
            req_mode_o  <= mode_i;
         end else if (req_valid_o && ready_i) begin
            // released mode lines show a changed value, not the last one
            req_valid_o <= 1'b0;
            req_mode_o  <= lpmc_mode_t'(~req_mode_o);
         end
         // an interrupt stays pending until the core runs again
         irq_o <= (state_i == LPMC_RUN) ? '0 : (irq_o | fire_i);
         if (resumed_i) begin
            reconfig_o <= 1'b1;
         end else if (go_i) begin
            reconfig_o <= 1'b0;
         end
      end
   end
endmodule : lpmc_core_model

//--- verif/tb.sv
// testbench: mode entry, wake and resume timing of the low power mode controller
module tb
   import lpmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int XC = 8;
   localparam int UC = 8;
   localparam int RI = IRC_RESUME_CYC * IRC_DIV;
   localparam int FL = FLASH_START_IRC * IRC_DIV;
   logic                clk      = 1'b0;
   logic                rst      = 1'b1;
   logic                go       = 1'b0;
   lpmc_mode_t          mode     = LPMC_REQ_NONE;
   logic [NUM_WAKE-1:0] fire     = '0;
   logic [NUM_WAKE-1:0] en       = '1;
   logic                prev_irc = 1'b1;
   logic                rtc_en   = 1'b0;
   logic                wdt_run  = 1'b0;
   logic                ready, resumed, valid, reconfig;
   lpmc_mode_t          rmode;
   logic [NUM_WAKE-1:0] irq;
   lpmc_ctrl_t          ctrl;
   lpmc_state_t         state;
   int                  err_total = 0;
   int                  checked   = 0;

   always #10 clk = ~clk;

   lpmc_top #(.XTAL_CYC(XC), .IRC_UP_CYC(UC)) i_lpmc_top (
      .CLK_I(clk), .RESET_I(rst), .REQ_VALID_I(valid), .REQ_MODE_I(rmode),
      .PREV_SRC_IRC_I(prev_irc), .RTC_ENABLED_I(rtc_en), .WDT_RUNNING_I(wdt_run),
      .WAKE_IRQ_I(irq), .WAKE_EN_I(en), .REQ_READY_O(ready), .CTRL_O(ctrl),
      .RESUMED_O(resumed), .STATE_O(state));

   lpmc_core_model i_lpmc_core_model (
      .clk_i(clk), .reset_i(rst), .go_i(go), .mode_i(mode), .fire_i(fire),
      .ready_i(ready), .state_i(state), .resumed_i(resumed), .req_valid_o(valid),
      .req_mode_o(rmode), .irq_o(irq), .reconfig_o(reconfig));

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run

   task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_vec

   task automatic chk_cnt(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : chk_cnt

   task automatic give_up(input logic [31:0] got, input logic [31:0] exp);
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      complete_run();
   endtask : give_up

   task automatic wait_state(input lpmc_state_t s, input int lim);
      int n = 0;
      @(negedge clk);
      while (state !== s && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (state !== s) give_up(state, s);
   endtask : wait_state

   // cycles spent in a state, and whether resume pulsed in its last cycle
   task automatic dwell(input lpmc_state_t s, output int n, output logic r);
      n = 0;
      r = 1'b0;
      while (state === s && n < 10000) begin
         r = resumed;
         @(negedge clk);
         n++;
      end
      if (state === s) give_up(n, 10000);
   endtask : dwell

   task automatic request(input lpmc_mode_t m);
      // gap lets the wake synchronisers flush the last interrupt
      repeat (4) @(posedge clk);
      go   <= 1'b1;
      mode <= m;
      @(posedge clk);
      go <= 1'b0;
   endtask : request

   task automatic pulse_irq(input int b);
      @(posedge clk);
      fire <= NUM_WAKE'(1) << b;
      @(posedge clk);
      fire <= '0;
   endtask : pulse_irq

   task automatic t_reset();
      lpmc_ctrl_t rv = '1;
      rv.clkdiv_clear = 1'b0;
      rv.clksel_reset = 1'b0;
      rv.pin_hold     = 1'b0;
      @(negedge clk);
      chk_vec(state, LPMC_RUN);
      chk_vec(ctrl, rv);
      chk_vec(ready, 1'b1);
      request(LPMC_REQ_NONE);
      repeat (4) @(negedge clk);
      chk_vec(state, LPMC_RUN);
      $display("test reset done");
   endtask : t_reset

   task automatic t_sleep();
      @(posedge clk);
      en <= NUM_WAKE'(1) << WK_OTHER;
      request(LPMC_REQ_SLEEP);
      wait_state(LPMC_SLEEP, 10);
      chk_vec({ctrl.cpu_clk_en, ctrl.flash_pwr_en, ctrl.sram_en, ctrl.dma_clk_en}, 4'h1);
      pulse_irq(WK_NMI);
      repeat (8) @(negedge clk);
      chk_vec(state, LPMC_SLEEP);
      pulse_irq(WK_OTHER);
      wait_state(LPMC_RUN, 60);
      $display("test sleep done");
   endtask : t_sleep

   task automatic t_deep(input int b, input logic pirc);
      int n;
      logic r;
      @(posedge clk);
      en       <= '1;
      prev_irc <= pirc;
      request(LPMC_REQ_DEEP);
      wait_state(LPMC_DEEP, 10);
      chk_vec({ctrl.pll_en, ctrl.pll_connect, ctrl.clkdiv_clear}, 3'h1);
      chk_vec({ctrl.irc_out_en, ctrl.irc_pwr_en, ctrl.rtc_osc_en}, 3'h3);
      chk_vec({ctrl.flash_pwr_en, ctrl.main_osc_en, ctrl.cpu_clk_en}, 3'h4);
      chk_vec({ctrl.pin_hold, ready, ctrl.dma_clk_en, reconfig}, 4'h8);
      pulse_irq(WK_OTHER);
      repeat (8) @(negedge clk);
      chk_vec(state, LPMC_DEEP);
      pulse_irq(b);
      wait_state(LPMC_RESUME, 10);
      dwell(LPMC_RESUME, n, r);
      if (pirc) chk_cnt(n, RI - 4, RI + 3);
      else chk_cnt(n, XC - 1, XC + 2);
      chk_vec({r, state}, {1'b1, LPMC_RUN});
      chk_vec(reconfig, 1'b1);
      $display("test deep-sleep wake %0d done", b);
   endtask : t_deep

   task automatic t_pdown(input logic rtc, input logic wdt, input logic pirc);
      int nu, nr, k;
      logic r;
      @(posedge clk);
      rtc_en   <= rtc;
      wdt_run  <= wdt;
      prev_irc <= pirc;
      request(LPMC_REQ_PDOWN);
      wait_state(LPMC_PDOWN, 10);
      chk_vec({ctrl.irc_pwr_en, ctrl.irc_out_en, ctrl.flash_pwr_en}, 3'h0);
      chk_vec({ctrl.main_osc_en, ctrl.rtc_osc_en, ctrl.wdt_osc_en}, {1'b0, rtc, wdt});
      chk_vec({ctrl.pll_en, ctrl.clksel_reset, ctrl.clkdiv_clear}, 3'h3);
      pulse_irq(rtc ? WK_RTC : WK_EXT0);
      nu = 0;
      if (pirc) begin
         wait_state(LPMC_OSC_UP, 10);
         dwell(LPMC_OSC_UP, nu, r);
         chk_cnt(nu, UC - 1, UC + 1);
      end else begin
         wait_state(LPMC_RESUME, 10);
      end
      chk_vec({state, ctrl.flash_access_en}, {LPMC_RESUME, 1'b0});
      dwell(LPMC_RESUME, nr, r);
      chk_vec({r, reconfig}, 2'h3);
      if (pirc) chk_cnt(nr, RI - 4, RI + 3);
      else chk_cnt(nr, XC - 1, XC + 2);
      k = 0;
      while (ctrl.flash_access_en !== 1'b1 && k < 8000) begin
         @(negedge clk);
         k++;
      end
      if (ctrl.flash_access_en !== 1'b1) give_up(k, 8000);
      chk_cnt(nu + nr + k, FL - 40, FL + UC + RI + 40);
      $display("test power-down done");
   endtask : t_pdown

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_sleep();
      for (int b = 0; b <= WK_WDT; b++) t_deep(b, 1'b1);
      t_deep(WK_CAN, 1'b0);
      t_pdown(1'b1, 1'b0, 1'b1);
      t_pdown(1'b0, 1'b1, 1'b0);
      request(LPMC_REQ_DEEP);
      wait_state(LPMC_DEEP, 10);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      complete_run();
   end
endmodule : tb
